// [design/pfs_pkg.sv]
// package for the pin-two function select block
// assumes a 32-bit AXI4-Lite register bus and a single 125 MHz clock
package pfs_pkg;
    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] PIN2_CONFIGURATION_IDX = 8'h0D;
    localparam logic [11:0] PIN2_CONFIGURATION_ADDR = 12'h034;
    localparam logic [11:0] IRQ_STATUS_ADDR = 12'h040;
    localparam logic [11:0] IRQ_MASK_ADDR = 12'h044;
    localparam logic [11:0] PIN_STATE_ADDR = 12'h048;
    localparam logic [7:0] PIN2_CONFIGURATION_RESET = 8'h00;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int DRIVE_MSB = 7;
    localparam int DRIVE_LSB = 6;
    localparam int PULLUP_BIT = 5;
    localparam int SELECT_MSB = 4;
    localparam int IRQ_EDGE_BIT = 0;
    localparam int IRQ_RETX_BIT = 1;
    localparam int PULLUP_KOHM = 200;
    // ------------------------------------------------------------------
    // function selector codes
    // ------------------------------------------------------------------
    localparam logic [4:0] SEL_MCU_CLOCK = 5'h00;
    localparam logic [4:0] SEL_WAKEUP_TIMER = 5'h01;
    localparam logic [4:0] SEL_BATTERY_LOW = 5'h02;
    localparam logic [4:0] SEL_DIRECT_IN = 5'h03;
    localparam logic [4:0] SEL_IRQ_FALL = 5'h04;
    localparam logic [4:0] SEL_IRQ_RISE = 5'h05;
    localparam logic [4:0] SEL_IRQ_CHANGE = 5'h06;
    localparam logic [4:0] SEL_ADC_IN = 5'h07;
    localparam logic [4:0] SEL_DIRECT_OUT = 5'h0A;
    localparam logic [4:0] SEL_RX_CLOCK = 5'h0F;
    localparam logic [4:0] SEL_RETX_REQ = 5'h11;
    localparam logic [4:0] SEL_RX_DATA = 5'h14;
    localparam logic [4:0] SEL_RX_STATE = 5'h15;
    localparam logic [4:0] SEL_FIFO_AFULL = 5'h16;
    localparam logic [4:0] SEL_ANT1 = 5'h17;
    localparam logic [4:0] SEL_ANT2 = 5'h18;
    localparam logic [4:0] SEL_PRE_VALID = 5'h19;
    localparam logic [4:0] SEL_PRE_INVALID = 5'h1A;
    localparam logic [4:0] SEL_SYNC = 5'h1B;
    localparam logic [4:0] SEL_CCA = 5'h1C;
    localparam logic [4:0] SEL_HIGH = 5'h1D;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// [design/pfs_cfg_if.sv]
// interface carrying the pin configuration from the bus slave to the pin mux
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface pfs_cfg_if;
    logic [7:0] cfg;
    logic       pin_in;
    logic       edge_evt;
    logic       retx_evt;
    logic       pin_out;
    logic       pin_oe;
    logic       pullup_on;
    logic       adc_sel;
    logic       din;
    modport slave (output cfg, pin_in, input edge_evt, retx_evt, pin_out, pin_oe,
                   pullup_on, adc_sel, din);
    modport mux (input cfg, pin_in, output edge_evt, retx_evt, pin_out, pin_oe,
                 pullup_on, adc_sel, din);
endinterface

// [design/pfs_pin_mux.sv]
// pin-two function mux: routes internal sources to the pin or samples it
// assumes all sources are synchronous to clk
`timescale 1ns/100ps
module pfs_pin_mux (
    input  wire logic clk,          // system clock
    input  wire logic resetn,       // async reset, active low
    input  wire logic [14:0] src,   // internal output sources
    pfs_cfg_if.mux    cif           // configuration and pin signals
);
    logic [4:0] sel;
    logic       prev_in;
    logic       next_out;
    logic       next_oe;
    logic       next_evt;
    logic       is_input;
    assign sel = cif.cfg[pfs_pkg::SELECT_MSB:0];
    // ------------------------------------------------------------------
    // output selection
    // ------------------------------------------------------------------
    always_comb begin
        next_out = 1'b0;
        next_oe = 1'b1;
        is_input = 1'b0;
        case (sel)
            pfs_pkg::SEL_MCU_CLOCK: next_out = src[0];
            pfs_pkg::SEL_WAKEUP_TIMER: next_out = src[1];
            pfs_pkg::SEL_BATTERY_LOW: next_out = src[2];
            pfs_pkg::SEL_DIRECT_OUT: next_out = src[3];
            pfs_pkg::SEL_RX_CLOCK: next_out = src[4];
            pfs_pkg::SEL_RX_DATA: next_out = src[5];
            pfs_pkg::SEL_RX_STATE: next_out = src[6];
            pfs_pkg::SEL_FIFO_AFULL: next_out = src[7];
            pfs_pkg::SEL_ANT1: next_out = src[8];
            pfs_pkg::SEL_ANT2: next_out = src[9];
            pfs_pkg::SEL_PRE_VALID: next_out = src[10];
            pfs_pkg::SEL_SYNC: next_out = src[11];
            pfs_pkg::SEL_PRE_INVALID: next_out = src[12];
            pfs_pkg::SEL_CCA: next_out = src[13];
            pfs_pkg::SEL_HIGH: next_out = 1'b1;
            pfs_pkg::SEL_DIRECT_IN, pfs_pkg::SEL_IRQ_FALL, pfs_pkg::SEL_IRQ_RISE,
            pfs_pkg::SEL_IRQ_CHANGE, pfs_pkg::SEL_RETX_REQ: begin
                next_oe = 1'b0;
                is_input = 1'b1;
            end
            pfs_pkg::SEL_ADC_IN: next_oe = 1'b0;
            default: next_out = 1'b0;
        endcase
    end
    // ------------------------------------------------------------------
    // edge detection for the external interrupt modes
    // ------------------------------------------------------------------
    always_comb begin
        case (sel)
            pfs_pkg::SEL_IRQ_FALL: next_evt = prev_in & ~cif.pin_in;
            pfs_pkg::SEL_IRQ_RISE: next_evt = ~prev_in & cif.pin_in;
            pfs_pkg::SEL_IRQ_CHANGE: next_evt = prev_in ^ cif.pin_in;
            default: next_evt = 1'b0;
        endcase
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev_in <= 1'b0;
            cif.pin_out <= 1'b0;
            cif.pin_oe <= 1'b0;
            cif.pullup_on <= 1'b0;
            cif.adc_sel <= 1'b0;
            cif.din <= 1'b0;
            cif.edge_evt <= 1'b0;
            cif.retx_evt <= 1'b0;
        end else begin
            prev_in <= cif.pin_in;
            cif.pin_out <= next_out;
            cif.pin_oe <= next_oe;
            cif.pullup_on <= is_input & cif.cfg[pfs_pkg::PULLUP_BIT];
            cif.adc_sel <= (sel == pfs_pkg::SEL_ADC_IN);
            cif.din <= is_input & cif.pin_in;
            cif.edge_evt <= next_evt;
            cif.retx_evt <= (sel == pfs_pkg::SEL_RETX_REQ) & ~prev_in & cif.pin_in;
        end
    end
endmodule // pfs_pin_mux

// [design/pfs_top.sv]
// top of the pin-two function select block with its AXI4-Lite register slave
// assumes AXI4-Lite master on the same clock and internal sources synchronous
// Notes on behaviour
// - bits 7:6 hold drive strength, read/write
// - bit 5 is pull-up enable, read/write
// - pull-up only when pin is digital input
// - bits 4:0 select; 00000 outputs controller clock
// - 00001 outputs wake-up timer expired status
// - 00010 outputs battery-low status
// - 00011 pin is sampled digital input
// - 00100/00101/00110 interrupt on fall/rise/change
// - 00111 routes pin to converter input
// - 01010 drives direct digital output source
// - 01111 outputs recovered receive data clock
// - 10001 accepts external retransmission request
// - 11001 valid preamble, 11011 sync detected
// - 10100/10101/10110 rx data, state, fifo almost full
// - 10111/11000 antenna switch one and two
// - 11010 invalid preamble, 11100 channel assessment
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/100ps
module pfs_top (
    input  wire logic        clk,             // 125 MHz clock
    input  wire logic        resetn,          // async reset, active low
    input  wire logic [11:0] s_axi_awaddr,    // write address
    input  wire logic        s_axi_awvalid,   // write address valid
    output logic             s_axi_awready,   // write address ready
    input  wire logic [31:0] s_axi_wdata,     // write data
    input  wire logic [3:0]  s_axi_wstrb,     // write strobes
    input  wire logic        s_axi_wvalid,    // write data valid
    output logic             s_axi_wready,    // write data ready
    output logic [1:0]       s_axi_bresp,     // write response
    output logic             s_axi_bvalid,    // write response valid
    input  wire logic        s_axi_bready,    // write response ready
    input  wire logic [11:0] s_axi_araddr,    // read address
    input  wire logic        s_axi_arvalid,   // read address valid
    output logic             s_axi_arready,   // read address ready
    output logic [31:0]      s_axi_rdata,     // read data
    output logic [1:0]       s_axi_rresp,     // read response
    output logic             s_axi_rvalid,    // read data valid
    input  wire logic        s_axi_rready,    // read data ready
    input  wire logic [14:0] src,             // internal sources, see handover
    input  wire logic        pin_i,           // pin level in
    output logic             pin_o,           // pin level out
    output logic             pin_oe,          // pin output enable
    output logic             pin_pullup_en,   // connect the pull-up
    output logic [1:0]       pin_drive,       // drive strength to pad
    output logic             adc_input_sel,   // pin routed to converter
    output logic             direct_in,       // sampled direct input
    output logic             irq              // level interrupt
);
    pfs_cfg_if cif ();
    logic [7:0]  cfg;
    logic [7:0]  next_cfg;
    logic [1:0]  irq_status;
    logic [1:0]  next_status;
    logic [1:0]  irq_mask;
    logic [1:0]  next_mask;
    logic        aw_held;
    logic        w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        next_aw_held;
    logic        next_w_held;
    logic        do_write;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic [1:0]  w1c;
    logic        wr_hit;

    assign cif.cfg = cfg;
    assign cif.pin_in = pin_i;

    pfs_pin_mux u_mux (
        .clk    (clk),
        .resetn (resetn),
        .src    (src),
        .cif    (cif.mux)
    );
    // ------------------------------------------------------------------
    // write channel: address and data taken in either order
    // ------------------------------------------------------------------
    always_comb begin
        next_aw_held = aw_held | (s_axi_awvalid & s_axi_awready);
        next_w_held = w_held | (s_axi_wvalid & s_axi_wready);
        do_write = next_aw_held & next_w_held & ~s_axi_bvalid;
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
        end
        next_bvalid = s_axi_bvalid & ~s_axi_bready;
        next_bresp = s_axi_bresp;
        if (do_write) begin
            next_bvalid = 1'b1;
            next_bresp = pfs_pkg::AXI_OKAY;
        end
    end
    logic [11:0] wa;
    logic [31:0] wd;
    logic [3:0]  ws;
    always_comb begin
        wa = aw_held ? aw_addr : s_axi_awaddr;
        wd = w_held ? w_data : s_axi_wdata;
        ws = w_held ? w_strb : s_axi_wstrb;
        wr_hit = do_write & ws[0];
        next_cfg = cfg;
        next_mask = irq_mask;
        w1c = 2'h0;
        if (wr_hit) begin
            case (wa)
                pfs_pkg::PIN2_CONFIGURATION_ADDR: next_cfg = wd[7:0];
                pfs_pkg::IRQ_MASK_ADDR: next_mask = wd[1:0];
                pfs_pkg::IRQ_STATUS_ADDR: w1c = wd[1:0];
                default: next_cfg = cfg;
            endcase
        end
        // hardware set wins over a same-cycle software clear
        next_status = (irq_status & ~w1c);
        next_status[pfs_pkg::IRQ_EDGE_BIT] = next_status[pfs_pkg::IRQ_EDGE_BIT] | cif.edge_evt;
        next_status[pfs_pkg::IRQ_RETX_BIT] = next_status[pfs_pkg::IRQ_RETX_BIT] | cif.retx_evt;
    end
    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    always_comb begin
        next_rvalid = s_axi_rvalid & ~s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_arvalid & s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = pfs_pkg::AXI_OKAY;
            case (s_axi_araddr)
                pfs_pkg::PIN2_CONFIGURATION_ADDR: next_rdata = {24'h000000, cfg};
                pfs_pkg::IRQ_STATUS_ADDR: next_rdata = {30'h00000000, irq_status};
                pfs_pkg::IRQ_MASK_ADDR: next_rdata = {30'h00000000, irq_mask};
                pfs_pkg::PIN_STATE_ADDR: next_rdata = {29'h00000000, cif.din, cif.pin_oe,
                                                       cif.pin_out};
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = pfs_pkg::AXI_SLVERR;
                end
            endcase
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg <= pfs_pkg::PIN2_CONFIGURATION_RESET;
            irq_status <= 2'h0;
            irq_mask <= pfs_pkg::IRQ_MASK_RESET;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
            pin_o <= 1'b0;
            pin_oe <= 1'b0;
            pin_pullup_en <= 1'b0;
            pin_drive <= 2'h0;
            adc_input_sel <= 1'b0;
            direct_in <= 1'b0;
            irq <= 1'b0;
        end else begin
            cfg <= next_cfg;
            irq_status <= next_status;
            irq_mask <= next_mask;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            if (s_axi_awvalid & s_axi_awready) aw_addr <= s_axi_awaddr;
            if (s_axi_wvalid & s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            s_axi_awready <= ~next_aw_held & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready <= ~next_w_held & ~(s_axi_wvalid & s_axi_wready);
            s_axi_arready <= ~next_rvalid & ~(s_axi_arvalid & s_axi_arready);
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            pin_o <= cif.pin_out;
            pin_oe <= cif.pin_oe;
            pin_pullup_en <= cif.pullup_on;
            pin_drive <= cfg[pfs_pkg::DRIVE_MSB:pfs_pkg::DRIVE_LSB];
            adc_input_sel <= cif.adc_sel;
            direct_in <= cif.din;
            irq <= |(next_status & irq_mask);
        end
    end
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_pullup_only_input;
        @(posedge clk) disable iff (!resetn)
        pin_pullup_en |-> !pin_oe && !adc_input_sel;
    endproperty
    a_pullup_only_input: assert property (p_pullup_only_input)
        else $error("pull-up on while pin not a digital input");
    property p_drive_follows;
        @(posedge clk) disable iff (!resetn)
        $changed(cfg[7:6]) |=> pin_drive == $past(cfg[7:6]);
    endproperty
    a_drive_follows: assert property (p_drive_follows)
        else $error("drive strength not passed to pad");
    property p_mcu_clock;
        @(posedge clk) disable iff (!resetn)
        (resetn && cfg[4:0] == 5'h00) [*3] |-> pin_o == $past(src[0], 2) && pin_oe;
    endproperty
    a_mcu_clock: assert property (p_mcu_clock)
        else $error("controller clock not on pin");
    property p_wakeup;
        @(posedge clk) disable iff (!resetn)
        (cfg[4:0] == 5'h01) [*3] |-> pin_o == $past(src[1], 2);
    endproperty
    a_wakeup: assert property (p_wakeup)
        else $error("wake-up timer status not on pin");
    property p_battery;
        @(posedge clk) disable iff (!resetn)
        (cfg[4:0] == 5'h02) [*3] |-> pin_o == $past(src[2], 2);
    endproperty
    a_battery: assert property (p_battery)
        else $error("battery status not on pin");
    property p_input_released;
        @(posedge clk) disable iff (!resetn)
        (cfg[4:0] == 5'h03 || cfg[4:0] == 5'h07) [*3] |-> !pin_oe;
    endproperty
    a_input_released: assert property (p_input_released)
        else $error("pin driven while an input");
    property p_rise_irq;
        @(posedge clk) disable iff (!resetn)
        (cfg[4:0] == 5'h05) && !pin_i ##1 pin_i && cfg[4:0] == 5'h05 |-> ##2 irq_status[0];
    endproperty
    a_rise_irq: assert property (p_rise_irq)
        else $error("rising edge did not set status");
    property p_high_code;
        @(posedge clk) disable iff (!resetn)
        (cfg[4:0] == 5'h1D) [*3] |-> pin_o && pin_oe;
    endproperty
    a_high_code: assert property (p_high_code)
        else $error("code after assessment not high");
    property p_low_default;
        @(posedge clk) disable iff (!resetn)
        (cfg[4:0] == 5'h1E) [*3] |-> !pin_o && pin_oe;
    endproperty
    a_low_default: assert property (p_low_default)
        else $error("unlisted code not low");
    c_write: cover property (@(posedge clk) disable iff (!resetn) s_axi_bvalid && s_axi_bready);
    c_irq: cover property (@(posedge clk) disable iff (!resetn) irq);
    c_input: cover property (@(posedge clk) disable iff (!resetn) pin_pullup_en);
endmodule // pfs_top

// [tb/pfs_pin_partner.sv]
// board logic on the far side of pin two
// assumes one clock; the board drives the pin only when told to
`timescale 1ns/100ps
module pfs_pin_partner (
    input  wire logic clk,      // system clock
    input  wire logic drv_en,   // board drives the pin
    input  wire logic drv_val,  // level the board drives
    input  wire logic pin_o,    // block pin value
    input  wire logic pin_oe,   // block drives the pin
    input  wire logic pull_en,  // block pull-up connected
    output logic      pin_lvl   // resolved pin level
);
    logic float_q = 1'h0;
    // an undriven pin without pull-up wanders every cycle
    always @(posedge clk) float_q <= ~float_q;
    always_comb begin
        if (pin_oe)
            pin_lvl = pin_o;
        else if (drv_en)
            pin_lvl = drv_val;
        else if (pull_en)
            pin_lvl = 1'h1;
        else
            pin_lvl = float_q;
    end
endmodule // pfs_pin_partner

// [tb/pin2_function_select_cfg_bench.sv]
// self-checking bench for the pin-two function select block
// assumes the design package, interface and top are compiled first
`timescale 1ns/100ps
module pin2_function_select_cfg_bench;
    logic        clk = 1'h0;
    logic        resetn = 1'h0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rr;
    logic [14:0] src = '0;
    logic        drv_en = 1'h0, drv_val = 1'h0, pin_lvl;
    logic        pin_o, pin_oe, pull_en, adc_sel, din, irq;
    logic [1:0]  drive;
    int          failures = 0, tests_run = 0;
    logic [4:0]  codes [14] = '{5'h00, 5'h01, 5'h02, 5'h0A, 5'h0F, 5'h14, 5'h15,
                                5'h16, 5'h17, 5'h18, 5'h19, 5'h1B, 5'h1A, 5'h1C};

    always #4 clk = ~clk;

    pfs_top i_dut (.clk(clk), .resetn(resetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .src(src), .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_pullup_en(pull_en), .pin_drive(drive), .adc_input_sel(adc_sel),
        .direct_in(din), .irq(irq));

    pfs_pin_partner i_partner (.clk(clk), .drv_en(drv_en), .drv_val(drv_val),
        .pin_o(pin_o), .pin_oe(pin_oe), .pull_en(pull_en), .pin_lvl(pin_lvl));

    // ------------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            n++;
        end while (bvalid !== 1'h1 && n < 64);
        bready <= 1'h0;
        if (n >= 64) begin
            failures++;
            tally_and_finish();
        end
        chk("bresp", 32'(bresp), 32'(pfs_pkg::AXI_OKAY));
    endtask

    task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
            n++;
        end while (rvalid !== 1'h1 && n < 64);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        if (n >= 64) begin
            failures++;
            tally_and_finish();
        end
    endtask

    // pin outputs follow the register two cycles after the write lands
    task automatic setcfg(input logic [7:0] c);
        axw(pfs_pkg::PIN2_CONFIGURATION_ADDR, {24'h0, c});
        repeat (4) @(posedge clk);
    endtask

    task automatic edge_case(input logic [4:0] code, input logic v0, input logic [1:0] st);
        drv_en <= 1'h1;
        drv_val <= v0;
        setcfg({3'h0, code});
        axw(pfs_pkg::IRQ_STATUS_ADDR, 32'h3);
        repeat (2) @(posedge clk);
        chk("irq idle", irq, 32'h0);
        drv_val <= ~v0;
        repeat (6) @(posedge clk);
        chk("irq edge", irq, {31'h0, |st});
        axr(pfs_pkg::IRQ_STATUS_ADDR, rd, rr);
        chk("status", rd, {30'h0, st});
        axw(pfs_pkg::IRQ_STATUS_ADDR, {30'h0, st});
        repeat (2) @(posedge clk);
        chk("irq cleared", irq, 32'h0);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'h1;
        repeat (2) @(posedge clk);
        axr(pfs_pkg::PIN2_CONFIGURATION_ADDR, rd, rr);
        chk("cfg reset", rd, 32'(pfs_pkg::PIN2_CONFIGURATION_RESET));
        setcfg(8'hE3);
        axr(pfs_pkg::PIN2_CONFIGURATION_ADDR, rd, rr);
        chk("cfg readback", rd, 32'hE3);
        chk("drive", drive, 32'h3);
        chk("pullup in", pull_en, 32'h1);
        chk("released", pin_oe, 32'h0);
        chk("pulled din", din, 32'h1);
        drv_en <= 1'h1;
        repeat (4) @(posedge clk);
        chk("din low", din, 32'h0);
        drv_en <= 1'h0;
        setcfg(8'h67);
        chk("adc sel", adc_sel, 32'h1);
        chk("pullup adc", pull_en, 32'h0);
        chk("adc drive", drive, 32'h1);
        for (int i = 0; i < 14; i++) begin
            setcfg({3'h0, codes[i]});
            src <= 15'h1 << i;
            repeat (3) @(posedge clk);
            chk("src high", {pin_oe, pin_o}, 32'h3);
            chk("pullup out", pull_en, 32'h0);
            src <= ~(15'h1 << i);
            repeat (3) @(posedge clk);
            chk("src low", pin_o, 32'h0);
        end
        src <= '0;
        setcfg(8'h1D);
        chk("const high", pin_o, 32'h1);
        axr(pfs_pkg::PIN_STATE_ADDR, rd, rr);
        chk("pin state high", rd, 32'h3);
        src <= 15'h7FFF;
        setcfg(8'h1E);
        chk("const low", pin_o, 32'h0);
        axw(pfs_pkg::IRQ_MASK_ADDR, 32'h3);
        @(posedge clk);
        edge_case(5'h04, 1'h1, 2'h1);
        edge_case(5'h04, 1'h0, 2'h0);
        edge_case(5'h05, 1'h0, 2'h1);
        edge_case(5'h05, 1'h1, 2'h0);
        edge_case(5'h06, 1'h1, 2'h1);
        edge_case(5'h06, 1'h0, 2'h1);
        edge_case(5'h11, 1'h0, 2'h2);
        axw(pfs_pkg::IRQ_MASK_ADDR, 32'h0);
        // a retransmission request is taken on a rising pin only
        drv_val <= 1'h0;
        repeat (2) @(posedge clk);
        drv_val <= 1'h1;
        repeat (6) @(posedge clk);
        chk("masked irq", irq, 32'h0);
        axr(pfs_pkg::IRQ_STATUS_ADDR, rd, rr);
        chk("masked status", rd, 32'h2);
        @(posedge clk);
        axr(12'h050, rd, rr);
        chk("unmapped resp", 32'(rr), 32'(pfs_pkg::AXI_SLVERR));
        chk("unmapped data", rd, 32'h0);
        tally_and_finish();
    end
endmodule // pin2_function_select_cfg_bench
